// *** bsalt_pkg.sv ***
// shared constants for the boundary-scan converter limit test
// assumes a single core clock; both ends import this package
package bsalt_pkg;

	// ----------------------------------------------------------------
	// scan chain layout (bit 0 is shifted out first)
	// ----------------------------------------------------------------
	localparam int CHAIN_LEN   = 35;
	localparam int DAC_W       = 10;
	localparam int CHSEL_W     = 8;
	localparam int NEG_INPUT_SELECT_W    = 3;
	localparam int POS_PULLUP  = 0;
	localparam int POS_PINDIR  = 1;
	localparam int POS_PINDATA = 2;
	localparam int POS_SUPREF  = 3;
	localparam int POS_SETTLE  = 4;
	localparam int POS_COMPARATOR_PRECHARGE_N   = 5;
	localparam int POS_AMP_PASSGATE_ENABLE  = 6;
	localparam int POS_NEG_INPUT_SELECT  = 7;
	localparam int POS_CHSEL   = 10;
	localparam int POS_IREF    = 18;
	localparam int POS_HOLD    = 19;
	localparam int POS_GND     = 20;
	localparam int POS_DAC     = 21;
	localparam int POS_AMP_POWER_ENABLE   = 31;
	localparam int POS_CONVERTER_ENABLE   = 32;
	localparam int POS_SWITCHCAP_TEST_ENABLE  = 33;
	localparam int POS_COMP    = 34;

	typedef logic [CHAIN_LEN-1:0] bsalt_chain_t;

	// ----------------------------------------------------------------
	// idle and test values
	// ----------------------------------------------------------------
	localparam logic [DAC_W-1:0]   DAC_MIDPOINT = 10'h200;
	localparam logic [CHSEL_W-1:0] CHSEL_IDLE   = 8'h01;
	localparam logic [CHSEL_W-1:0] CHSEL_TEST   = 8'h08;
	localparam bsalt_chain_t IDLE_VEC =
		(bsalt_chain_t'(DAC_MIDPOINT) << POS_DAC) |
		(bsalt_chain_t'(CHSEL_IDLE) << POS_CHSEL) |
		(bsalt_chain_t'(1) << POS_HOLD) |
		(bsalt_chain_t'(1) << POS_AMP_PASSGATE_ENABLE) |
		(bsalt_chain_t'(1) << POS_COMPARATOR_PRECHARGE_N);

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS         = 100;
	localparam int TCK_HALF       = 4;
	localparam int ACLK_HALF      = 4;
	localparam int DUMMY_COMPARES = 10;
	localparam int DUMMY_WAIT_NS  = 200;
	localparam int DUMMY_WAIT_CYC = (DUMMY_WAIT_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------------------------------
	// procedure steps, counted from 0
	// ----------------------------------------------------------------
	localparam int NUM_STEPS      = 11;
	localparam int STEP_SAMPLE_A  = 1;
	localparam int STEP_SAMPLE_B  = 6;
	localparam int STEP_LOW_DAC   = 3;
	localparam int STEP_LOW_COMPARATOR_PRECHARGE_N = 4;
	localparam int STEP_LOW_CHECK = 5;
	localparam int STEP_HI_DAC    = 8;
	localparam int STEP_HI_COMPARATOR_PRECHARGE_N  = 9;
	localparam int STEP_HI_CHECK  = 10;

	// ----------------------------------------------------------------
	// tester register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_LIMITS = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int CTRL_START   = 0;
	localparam int LIM_LOW_LSB  = 0;
	localparam int LIM_HI_LSB   = 16;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_DONE    = 1;
	localparam int STAT_PASS    = 2;
	localparam int STAT_LOWOK   = 3;
	localparam int STAT_HIOK    = 4;
	localparam int STAT_STEP    = 8;

endpackage : bsalt_pkg

// *** bsalt_link_if.sv ***
// scan link between the tester and the converter scan cells
// assumes the bench resolves nothing: every wire has one driver
interface bsalt_link_if;
	logic tck;
	logic tdi;
	logic tdo;
	logic shiftEn;
	logic captureEn;
	logic updateEn;
	logic extest;

	modport tester (
		output tck,
		output tdi,
		output shiftEn,
		output captureEn,
		output updateEn,
		output extest,
		input  tdo
	);
	modport device (
		input  tck,
		input  tdi,
		input  shiftEn,
		input  captureEn,
		input  updateEn,
		input  extest,
		output tdo
	);
endinterface : bsalt_link_if

// *** bsalt_sync.sv ***
// two-flop synchroniser for signals from outside the core clock
// assumes the inputs are quasi-static levels relative to core_clk
module bsalt_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			meta    <= '0;
			syncOut <= '0;
		end else begin
			meta    <= asyncIn;
			syncOut <= meta;
		end
	end
endmodule : bsalt_sync

// *** bsalt_device.sv ***
// converter scan cells: shift/update register and analog-side drive
// assumes a tester on the link and the analog macro on the user side
module bsalt_device (
	input  wire logic                          core_clk,
	input  wire logic                          nrst,
	bsalt_link_if.device                       link,
	input  wire logic                          compareIn,
	output logic                               converterEnable,
	output logic                               ampPowerEnable,
	output logic [bsalt_pkg::DAC_W-1:0]        dacCode,
	output logic [bsalt_pkg::CHSEL_W-1:0]      inputChannelSelect,
	output logic [bsalt_pkg::NEG_INPUT_SELECT_W-1:0]     negInputSelect,
	output logic                               ampPassgateEnable,
	output logic                               switchcapTestEnable,
	output logic                               settleAssist,
	output logic                               supplyReferenceSelect,
	output logic                               sampleHold,
	output logic                               groundNegEnable,
	output logic                               bandgapNegEnable,
	output logic                               pinData,
	output logic                               pinDir,
	output logic                               pinPullup,
	output logic                               analogClk,
	output logic                               converterSettled
);
	import bsalt_pkg::*;

	// ----------------------------------------------------------------
	// link sampling
	// ----------------------------------------------------------------
	logic [6:0]   linkSync;
	logic         sTck, sTdi, sShift, sCapture, sUpdate, sExtest, sComp;
	logic         tckPrev, tckRise;
	bsalt_chain_t chain, upd, eff, captureVec;
	logic         extestMode, compLatch;

	bsalt_sync #(.WIDTH(7)) u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.asyncIn  ({link.tck, link.tdi, link.shiftEn, link.captureEn,
		            link.updateEn, link.extest, compareIn}),
		.syncOut  (linkSync)
	);
	assign {sTck, sTdi, sShift, sCapture, sUpdate, sExtest, sComp} =
		linkSync;
	assign tckRise = sTck & ~tckPrev;

	// ----------------------------------------------------------------
	// scan register
	// ----------------------------------------------------------------
	// outside extest the analog side sees idle values only
	assign eff = extestMode ? upd : IDLE_VEC;

	always_comb begin
		captureVec           = eff;
		captureVec[POS_COMP] = compLatch;
	end

	// shift register moves only on a link clock rise
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			tckPrev <= 1'b0;
			chain   <= '0;
		end else begin
			tckPrev <= sTck;
			if (tckRise && sCapture)
				chain <= captureVec;
			else if (tckRise && sShift)
				chain <= {sTdi, chain[CHAIN_LEN-1:1]};
		end
	end

	// update latch and instruction mode
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			upd        <= IDLE_VEC;
			extestMode <= 1'b0;
		end else if (tckRise && sUpdate) begin
			upd        <= chain;
			extestMode <= sExtest;
		end
	end

	// tdo registered from the shift stage
	always_ff @(posedge core_clk) begin
		if (!nrst)
			link.tdo <= 1'b0;
		else
			link.tdo <= chain[0];
	end

	// ----------------------------------------------------------------
	// analog clock divider
	// ----------------------------------------------------------------
	logic [3:0] aclkCnt;
	logic       aclkRise;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			aclkCnt   <= '0;
			analogClk <= 1'b0;
			aclkRise  <= 1'b0;
		end else if (aclkCnt == 4'(ACLK_HALF - 1)) begin
			aclkCnt   <= '0;
			analogClk <= ~analogClk;
			aclkRise  <= ~analogClk;
		end else begin
			aclkCnt  <= aclkCnt + 4'h1;
			aclkRise <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// analog drive
	// ----------------------------------------------------------------
	logic [NEG_INPUT_SELECT_W-1:0] negReq;
	logic                multiNeg;

	// more than one negative source would short them; drop all instead
	always_comb begin
		negReq   = eff[POS_CONVERTER_ENABLE] ? eff[POS_NEG_INPUT_SELECT +: NEG_INPUT_SELECT_W] : '0;
		multiNeg = ((negReq != '0) && eff[POS_GND]) ||
		           ((negReq != '0) && eff[POS_IREF]) ||
		           (eff[POS_GND] && eff[POS_IREF]);
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			converterEnable       <= IDLE_VEC[POS_CONVERTER_ENABLE];
			dacCode               <= DAC_MIDPOINT;
			inputChannelSelect    <= CHSEL_IDLE;
			negInputSelect        <= '0;
			ampPassgateEnable     <= IDLE_VEC[POS_AMP_PASSGATE_ENABLE];
			switchcapTestEnable   <= IDLE_VEC[POS_SWITCHCAP_TEST_ENABLE];
			settleAssist          <= IDLE_VEC[POS_SETTLE];
			supplyReferenceSelect <= IDLE_VEC[POS_SUPREF];
			sampleHold            <= IDLE_VEC[POS_HOLD];
			groundNegEnable       <= IDLE_VEC[POS_GND];
			bandgapNegEnable      <= IDLE_VEC[POS_IREF];
			pinData               <= 1'b0;
			pinDir                <= 1'b0;
			pinPullup             <= 1'b0;
		end else begin
			converterEnable       <= eff[POS_CONVERTER_ENABLE];
			dacCode               <= eff[POS_DAC +: DAC_W];
			inputChannelSelect    <= eff[POS_CHSEL +: CHSEL_W];
			negInputSelect        <= multiNeg ? '0 : negReq;
			ampPassgateEnable     <= eff[POS_AMP_PASSGATE_ENABLE];
			switchcapTestEnable   <= eff[POS_SWITCHCAP_TEST_ENABLE];
			settleAssist          <= eff[POS_SETTLE];
			supplyReferenceSelect <= eff[POS_SUPREF];
			sampleHold            <= eff[POS_HOLD];
			groundNegEnable       <= eff[POS_GND] & ~multiNeg;
			bandgapNegEnable      <= eff[POS_IREF] & ~multiNeg;
			pinData               <= eff[POS_PINDATA];
			pinDir                <= eff[POS_PINDIR];
			pinPullup             <= eff[POS_PULLUP];
		end
	end

	// amplifier may only switch on while the analog clock is high
	always_ff @(posedge core_clk) begin
		if (!nrst)
			ampPowerEnable <= 1'b0;
		else if (!eff[POS_AMP_POWER_ENABLE])
			ampPowerEnable <= 1'b0;
		else if (analogClk)
			ampPowerEnable <= 1'b1;
	end

	// low precharge lets the latch track the comparator without clearing it;
	// releasing it freezes the result for capture
	always_ff @(posedge core_clk) begin
		if (!nrst)
			compLatch <= 1'b0;
		else if (!eff[POS_COMPARATOR_PRECHARGE_N])
			compLatch <= sComp;
	end

	// ----------------------------------------------------------------
	// dummy conversion after enable
	// ----------------------------------------------------------------
	logic       convPrev;
	logic [3:0] comparesLeft, waitLeft;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			convPrev         <= 1'b0;
			comparesLeft     <= '0;
			waitLeft         <= '0;
			converterSettled <= 1'b0;
		end else begin
			convPrev <= eff[POS_CONVERTER_ENABLE];
			if (eff[POS_CONVERTER_ENABLE] && !convPrev) begin
				comparesLeft <= 4'(DUMMY_COMPARES);
				waitLeft     <= 4'(DUMMY_WAIT_CYC);
			end else begin
				if (aclkRise && comparesLeft != '0)
					comparesLeft <= comparesLeft - 4'h1;
				if (waitLeft != '0)
					waitLeft <= waitLeft - 4'h1;
			end
			converterSettled <= eff[POS_CONVERTER_ENABLE] && convPrev &&
			                    comparesLeft == '0 && waitLeft == '0;
		end
	end
endmodule : bsalt_device

// *** bsalt_tester.sv ***
// scan tester: runs the eleven-row limit check over the scan link
// assumes an APB master on core_clk and the converter scan cells
// on the far side of the link
//
// Operation
// - negative select held zero when unused
// - pass-gate enable cell, idle one
// - precharge is active low, rests high
// - switch-cap test routes amplifier to channel four
// - settle assist stays zero here
// - supply reference select, idle zero
// - only one negative sample source enabled
// - unused converter cells carry idle values
// - lower limit must read compare low
// - upper limit reads high; pass needs both
// - channel pin cells all held zero
// - wait 200ns after converter enable
// - DAC at midpoint while sampling
// - first row preload, later rows extest
// - check results on next row's shift-out
// - link clock fast enough for hold time
// - hold samples low, holds high
// - converter enable cell, idle zero
//
// Local design decisions: the address map and the APB slave port.
module bsalt_tester (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	bsalt_link_if.tester     link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	import bsalt_pkg::*;

	typedef enum {
		ST_IDLE,
		ST_CAPTURE,
		ST_SHIFT,
		ST_UPDATE,
		ST_SETTLE
	} bsalt_tstate_t;

	bsalt_tstate_t      state;
	logic [DAC_W-1:0]   limLow, limHigh;
	logic               busy, done, pass, lowOk, highOk;
	logic [3:0]         step;
	logic [5:0]         bitCnt;
	logic [3:0]         divCnt, waitCnt;
	logic               tick, tdoSync;
	bsalt_chain_t       rowOut, inVec;
	logic               apbWrite, startReq;
	logic [31:0]        statusWord;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// row contents: idle values except the procedure's own cells
	function automatic bsalt_chain_t rowVector(
		input logic [3:0]       st,
		input logic [DAC_W-1:0] lo,
		input logic [DAC_W-1:0] hi
	);
		bsalt_chain_t     v;
		logic [DAC_W-1:0] dac;
		v   = IDLE_VEC;
		dac = DAC_MIDPOINT;
		if (st == 4'(STEP_LOW_DAC) || st == 4'(STEP_LOW_COMPARATOR_PRECHARGE_N))
			dac = lo;
		if (st == 4'(STEP_HI_DAC) || st == 4'(STEP_HI_COMPARATOR_PRECHARGE_N))
			dac = hi;
		v[POS_CONVERTER_ENABLE]             = 1'b1;
		v[POS_CHSEL +: CHSEL_W]  = CHSEL_TEST;
		v[POS_DAC +: DAC_W]      = dac;
		v[POS_HOLD]   = !(st == 4'(STEP_SAMPLE_A) ||
		                  st == 4'(STEP_SAMPLE_B));
		v[POS_COMPARATOR_PRECHARGE_N]  = !(st == 4'(STEP_LOW_COMPARATOR_PRECHARGE_N) ||
		                  st == 4'(STEP_HI_COMPARATOR_PRECHARGE_N));
		// single pin source, no ground or bandgap path
		v[POS_NEG_INPUT_SELECT +: NEG_INPUT_SELECT_W] = '0;
		v[POS_GND]     = 1'b0;
		v[POS_IREF]    = 1'b0;
		v[POS_SETTLE]  = 1'b0;
		v[POS_AMP_POWER_ENABLE]   = 1'b0;
		v[POS_PINDATA] = 1'b0;
		v[POS_PINDIR]  = 1'b0;
		v[POS_PULLUP]  = 1'b0;
		return v;
	endfunction : rowVector

	function automatic logic addrKnown(input logic [7:0] a);
		return a == REG_CTRL || a == REG_LIMITS || a == REG_STATUS;
	endfunction : addrKnown

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	assign apbWrite = psel & penable & pready & pwrite & ~pslverr;
	assign startReq = apbWrite && paddr == REG_CTRL &&
	                  pwdata[CTRL_START] && !busy;

	always_comb begin
		statusWord                 = '0;
		statusWord[STAT_BUSY]      = busy;
		statusWord[STAT_DONE]      = done;
		statusWord[STAT_PASS]      = pass;
		statusWord[STAT_LOWOK]     = lowOk;
		statusWord[STAT_HIOK]      = highOk;
		statusWord[STAT_STEP +: 4] = step;
	end

	// no wait state: answer is prepared during the setup cycle
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (psel && !penable) begin
			pready  <= 1'b1;
			pslverr <= !addrKnown(paddr);
			case (paddr)
				REG_LIMITS: prdata <= (32'(limLow) << LIM_LOW_LSB) |
				                      (32'(limHigh) << LIM_HI_LSB);
				REG_STATUS: prdata <= statusWord;
				default:    prdata <= '0;
			endcase
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// limits may not change under a running check
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			limLow  <= '0;
			limHigh <= '0;
		end else if (apbWrite && paddr == REG_LIMITS && !busy) begin
			limLow  <= pwdata[LIM_LOW_LSB +: DAC_W];
			limHigh <= pwdata[LIM_HI_LSB +: DAC_W];
		end
	end

	// ----------------------------------------------------------------
	// link clock
	// ----------------------------------------------------------------
	bsalt_sync #(.WIDTH(1)) u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.asyncIn  (link.tdo),
		.syncOut  (tdoSync)
	);

	// short half period keeps hold-high rows well inside the hold time
	always_ff @(posedge core_clk) begin
		if (!nrst || state == ST_IDLE || state == ST_SETTLE) begin
			divCnt <= '0;
			tick   <= 1'b0;
		end else if (divCnt == 4'(TCK_HALF - 1)) begin
			divCnt <= '0;
			tick   <= 1'b1;
		end else begin
			divCnt <= divCnt + 4'h1;
			tick   <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// procedure sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state          <= ST_IDLE;
			busy           <= 1'b0;
			done           <= 1'b0;
			pass           <= 1'b0;
			lowOk          <= 1'b0;
			highOk         <= 1'b0;
			step           <= '0;
			bitCnt         <= '0;
			waitCnt        <= '0;
			rowOut         <= IDLE_VEC;
			inVec          <= '0;
			link.tck       <= 1'b0;
			link.tdi       <= 1'b0;
			link.shiftEn   <= 1'b0;
			link.captureEn <= 1'b0;
			link.updateEn  <= 1'b0;
			link.extest    <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (startReq) begin
						busy           <= 1'b1;
						done           <= 1'b0;
						pass           <= 1'b0;
						lowOk          <= 1'b0;
						highOk         <= 1'b0;
						step           <= '0;
						rowOut         <= rowVector(4'h0, limLow, limHigh);
						link.extest    <= 1'b0;
						link.captureEn <= 1'b1;
						state          <= ST_CAPTURE;
					end
				end
				ST_CAPTURE: begin
					if (tick) begin
						link.tck <= ~link.tck;
						if (link.tck) begin
							link.captureEn <= 1'b0;
							link.shiftEn   <= 1'b1;
							link.tdi       <= rowOut[0];
							bitCnt         <= '0;
							state          <= ST_SHIFT;
						end
					end
				end
				ST_SHIFT: begin
					if (tick) begin
						link.tck <= ~link.tck;
						if (!link.tck) begin
							inVec[bitCnt] <= tdoSync;
						end else if (bitCnt == 6'(CHAIN_LEN - 1)) begin
							link.shiftEn  <= 1'b0;
							link.updateEn <= 1'b1;
							state         <= ST_UPDATE;
							// shift-out reflects the previous row
							if (step == 4'(STEP_LOW_CHECK))
								lowOk <= !inVec[POS_COMP];
							if (step == 4'(STEP_HI_CHECK))
								highOk <= inVec[POS_COMP];
						end else begin
							bitCnt   <= bitCnt + 6'h1;
							link.tdi <= rowOut[bitCnt + 6'h1];
						end
					end
				end
				ST_UPDATE: begin
					if (tick) begin
						link.tck <= ~link.tck;
						if (link.tck) begin
							link.updateEn <= 1'b0;
							waitCnt       <= 4'(DUMMY_WAIT_CYC);
							state         <= ST_SETTLE;
						end
					end
				end
				ST_SETTLE: begin
					// rows stay apart by the converter warm-up time
					if (waitCnt != '0) begin
						waitCnt <= waitCnt - 4'h1;
					end else if (step == 4'(NUM_STEPS - 1)) begin
						busy  <= 1'b0;
						done  <= 1'b1;
						pass  <= lowOk & highOk;
						state <= ST_IDLE;
					end else begin
						step           <= step + 4'h1;
						rowOut         <= rowVector(step + 4'h1,
						                            limLow, limHigh);
						link.extest    <= 1'b1;
						link.captureEn <= 1'b1;
						state          <= ST_CAPTURE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule : bsalt_tester

// *** bsalt_link_chk.sv ***
// link-level checks between the scan tester and the converter cells
// assumes every link signal is a flop on core_clk, nrst sync low
module bsalt_link_chk (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic shiftEn,
	input wire logic captureEn,
	input wire logic updateEn,
	input wire logic extest
);
	timeunit 1ns;
	timeprecision 1ns;
	import bsalt_pkg::*;
	// ----------------------------------------------------------------
	// helper logic and sequences
	// ----------------------------------------------------------------
	logic [5:0] shiftCnt;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// shift rises in one row; cleared at capture so rows stay apart
	always_ff @(posedge core_clk) begin
		if (!nrst || captureEn) shiftCnt <= 6'h00;
		else if (shiftEn && $rose(tck)) shiftCnt <= shiftCnt + 6'h01;
	end
	// one link clock period, the qualifier dropping at its fall
	sequence oneTck(en);
		##[0:8] $rose(tck) ##0 tck[*4] ##1 (!tck && !en);
	endsequence
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	chk_tck_high_len: assert property (
		$rose(tck) |-> tck[*4] ##1 !tck)
		else $error("link clock high phase wrong");
	chk_tck_low_len: assert property ($fell(tck) |-> !tck[*4])
		else $error("link clock low phase too short");
	chk_tdi_on_fall: assert property (
		$changed(tdi) |-> $fell(tck))
		else $error("tdi moved away from a link clock fall");
	chk_ctrl_stable: assert property (tck |->
		$stable({shiftEn, captureEn, updateEn, extest, tdi}))
		else $error("link controls moved while clock high");
	chk_capture_one: assert property (
		$rose(captureEn) |-> oneTck(captureEn))
		else $error("capture not exactly one link clock");
	chk_update_one: assert property (
		$rose(updateEn) |-> oneTck(updateEn))
		else $error("update not exactly one link clock");
	chk_shift_count: assert property (
		$fell(shiftEn) |-> shiftCnt == CHAIN_LEN)
		else $error("row shifted a wrong number of bits");
	chk_modes_apart: assert property (!(shiftEn && (captureEn || updateEn)))
		else $error("shift overlaps capture or update");
	chk_tck_framed: assert property (tck |-> shiftEn || captureEn || updateEn)
		else $error("link clock ran outside a frame");
	chk_extest_row: assert property ($rose(extest) |-> captureEn)
		else $error("extest changed outside a row start");
endmodule : bsalt_link_chk

// *** tb_boundary_scan_adc_limit_test.sv ***
// bench: tester and converter cells joined by the scan link
// assumes an APB master here and a comparator modelled from dacCode
module tb_boundary_scan_adc_limit_test;
	timeunit 1ns;
	timeprecision 1ns;
	import bsalt_pkg::*;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic compareIn, converterEnable, ampPowerEnable, ampPassgateEnable;
	logic switchcapTestEnable, settleAssist, supplyReferenceSelect;
	logic sampleHold, groundNegEnable, bandgapNegEnable, pinData, pinDir;
	logic pinPullup, analogClk, converterSettled;
	logic [DAC_W-1:0] dacCode, vin;
	logic [CHSEL_W-1:0] inputChannelSelect;
	logic [NEG_INPUT_SELECT_W-1:0] negInputSelect;
	int n_errors, tests_run;
	bsalt_link_if bsalt_link_if_inst ();
	bsalt_tester bsalt_tester_inst (.core_clk(core_clk), .nrst(nrst),
		.link(bsalt_link_if_inst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	bsalt_device bsalt_device_inst (.core_clk(core_clk), .nrst(nrst),
		.link(bsalt_link_if_inst), .compareIn(compareIn),
		.converterEnable(converterEnable), .ampPowerEnable(ampPowerEnable),
		.dacCode(dacCode), .inputChannelSelect(inputChannelSelect),
		.negInputSelect(negInputSelect), .ampPassgateEnable(ampPassgateEnable),
		.switchcapTestEnable(switchcapTestEnable), .settleAssist(settleAssist),
		.supplyReferenceSelect(supplyReferenceSelect), .sampleHold(sampleHold),
		.groundNegEnable(groundNegEnable), .bandgapNegEnable(bandgapNegEnable),
		.pinData(pinData), .pinDir(pinDir), .pinPullup(pinPullup),
		.analogClk(analogClk), .converterSettled(converterSettled));
	bsalt_link_chk bsalt_link_chk_inst (.core_clk(core_clk), .nrst(nrst),
		.tck(bsalt_link_if_inst.tck), .tdi(bsalt_link_if_inst.tdi),
		.tdo(bsalt_link_if_inst.tdo), .shiftEn(bsalt_link_if_inst.shiftEn),
		.captureEn(bsalt_link_if_inst.captureEn),
		.updateEn(bsalt_link_if_inst.updateEn),
		.extest(bsalt_link_if_inst.extest));
	// ----------------------------------------------------------------
	// clock, comparator model, watchdog
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// comparator goes high once the threshold passes the pin voltage
	always @(posedge core_clk) compareIn <= (dacCode > vin);
	// three runs of about 3.3k cycles each fit well inside this span
	initial begin
		repeat (40000) @(posedge core_clk);
		n_errors++;
		report_and_stop();
	end
	// analog-side safety, watched on every cycle of the run
	always @(negedge core_clk) begin
		if (nrst) begin
			if (!sampleHold)
				check(dacCode, DAC_MIDPOINT);
			// the tester only ever picks the pin path, never a second one
			check({negInputSelect, groundNegEnable, bandgapNegEnable},
				0);
			check(settleAssist, 0);
			check(ampPowerEnable, 0);
			if (converterEnable)
				check({pinData, pinDir, pinPullup}, 0);
			if (converterSettled)
				check(converterEnable, 1);
		end
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	// one APB transfer, entered just after a rising edge; a stuck
	// slave is caught by the watchdog, not by a local limit
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	// idle cell values after reset, register defaults, unmapped place
	task automatic t_idle();
		// analog clock must flip once per half period
		@(negedge core_clk);
		rd[0] = analogClk;
		repeat (ACLK_HALF) @(negedge core_clk);
		check(analogClk, !rd[0]);
		@(posedge core_clk);
		check(negInputSelect, 0);
		check(ampPassgateEnable, 1);
		check(switchcapTestEnable, 0);
		check(supplyReferenceSelect, 0);
		check(converterEnable, 0);
		check({sampleHold, dacCode, inputChannelSelect},
			32'h00060001);
		apb(1'b0, REG_STATUS, 0);
		check(rd, 0);
		apb(1'b0, 8'h0c, 0);
		check(rd, 0);
		check(err, 1);
	endtask : t_idle
	// full limit check; limits written mid-run must be ignored
	task automatic t_run(input logic [9:0] v, input logic lo,
			input logic hi);
		int i;
		vin = v;
		apb(1'b1, REG_LIMITS, 32'h01430123);
		apb(1'b1, REG_CTRL, 1);
		apb(1'b1, REG_LIMITS, 0);
		apb(1'b0, REG_LIMITS, 0);
		check(rd, 32'h01430123);
		i = 0;
		do begin
			apb(1'b0, REG_STATUS, 0);
			i++;
		end while (rd[STAT_DONE] !== 1'b1 && i < 3000);
		check(rd[4:0], {hi, lo, lo & hi, 2'b10});
		check(converterEnable, 1);
		check(inputChannelSelect, CHSEL_TEST);
		check(converterSettled, 1);
	endtask : t_run
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = 0;
		vin = 10'h130;
		n_errors = 0;
		tests_run = 0;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_idle();
		t_run(10'h130, 1'b1, 1'b1);
		t_run(10'h150, 1'b1, 1'b0);
		t_run(10'h100, 1'b0, 1'b1);
		report_and_stop();
	end
endmodule : tb_boundary_scan_adc_limit_test
